// File: core/voice_pkg.sv
// Purpose: shared constants, types and decode for the voice recorder link
// Assumes: 40 MHz reference clock, 8 KHz sample rate part
// Notes: How it works list below
// How it works
// - selected only while slave select is low
// - host sets data half period before rise
// - data out released when not selected
// - sample on rising, shift on falling
// - host alone makes the serial clock
// - interrupt low on array or message end
// - interrupt pin only pulls low
// - marker or array ending raises the interrupt, a stop command does not
// - next transaction start releases the interrupt
// - flags returned for the read flags command
// - array end flag at last row
// - message end flag only in playback
// - eight marker positions per row
// - row tick one period per row
// - normal row: high 175 ms, low 25 ms
// - skip row: high 109.38 us, low 15.63 us
// - recording start adds one low-time of high
// - sampling clock pin pulled down
// - external clock divided by two at entry
// - external clock held at the fixed rate
// - unused external clock tied to ground
// - read flags byte 0X110XXX, flags shift out
// - transaction starts at select fall, high between
`default_nettype none
package voice_pkg;
	localparam int CLK_HZ      = 40_000_000;
	localparam int EXT_CLK_HZ  = 1_024_000;   // supplied sampling clock
	localparam int DIV_CLK_HZ  = EXT_CLK_HZ / 2;
	// internal sampling source, ref cycles per divided period
	localparam int INT_DIV_CYCLES = CLK_HZ / DIV_CLK_HZ;
	// host side ext clock half period, rounded down to whole cycles
	localparam int EXT_HALF_CYCLES = CLK_HZ / (2 * EXT_CLK_HZ);
	localparam int ROWS      = 2400;
	localparam int ROW_SLOTS = 8;
	localparam int SLOT_W    = $clog2(ROW_SLOTS);
	// row tick times in their own units
	localparam int ROW_LOW_TIME_US   = 25_000;
	localparam int ROW_HIGH_TIME_US  = 175_000;
	localparam int SKIP_LOW_TIME_NS  = 15_630;
	localparam int SKIP_HIGH_TIME_NS = 109_380;
	// counts of divided sampling cycles, rounded down
	localparam int ROW_LOW_CYCLES =
		(DIV_CLK_HZ / 1000) * ROW_LOW_TIME_US / 1000;
	localparam int ROW_HIGH_CYCLES =
		(DIV_CLK_HZ / 1000) * ROW_HIGH_TIME_US / 1000;
	localparam int SKIP_LOW_CYCLES =
		(DIV_CLK_HZ / 1000) * SKIP_LOW_TIME_NS / 1_000_000;
	localparam int SKIP_HIGH_CYCLES =
		(DIV_CLK_HZ / 1000) * SKIP_HIGH_TIME_NS / 1_000_000;
	// control byte field positions
	localparam int CMD_RUN_BIT  = 7;
	localparam int CMD_PLAY_BIT = 6;
	localparam int CMD_PU_BIT   = 5;
	localparam int CMD_IAB_BIT  = 4;
	localparam int CMD_SKIP_BIT = 3;
	localparam logic [7:0] READ_FLAGS_MASK  = 8'hB8;
	localparam logic [7:0] READ_FLAGS_VALUE = 8'h30;
	localparam int CTRL_BITS  = 8;
	localparam int ADDR_BITS  = 16;
	localparam int FRAME_BITS = CTRL_BITS + ADDR_BITS;
	// status word positions, first bit out is bit 0
	localparam int STAT_ARRAY_POS = 0;
	localparam int STAT_MSG_POS   = 1;
	localparam int STAT_ROW_POS   = 8;
	// host timing in reference cycles
	localparam int SCLK_HALF_CYCLES = 10;
	localparam int SS_GAP_CYCLES    = 20;

	typedef enum logic [1:0] {
		OP_IDLE = 2'b00,
		OP_PLAY = 2'b01,
		OP_REC  = 2'b10
	} op_e;

	typedef enum logic [1:0] {
		HS_IDLE = 2'b00,
		HS_LOW  = 2'b01,
		HS_HIGH = 2'b10,
		HS_GAP  = 2'b11
	} host_state_e;

	// matches the read flags pattern, x positions ignored
	function automatic logic read_flags_cmd(input logic [7:0] c);
		return (c & READ_FLAGS_MASK) == READ_FLAGS_VALUE;
	endfunction
endpackage
`default_nettype wire

// File: core/spi_link_if.sv
// Purpose: pins between the recorder and its host
// Assumes: open drain lines pulled up, sampling pin pulled down
// Notes: wire levels resolved here from the enables
`default_nettype none
interface spi_link_if;
	logic ss_n;             // slave select, low selects
	logic sclk;             // serial clock from host
	logic mosi;             // host to device data
	logic miso_val;         // device data value
	logic miso_oe;          // device drives data out
	logic miso;             // resolved data out
	logic int_oe;           // device pulls interrupt low
	logic int_line;         // resolved interrupt level
	logic row_tick_oe;      // device pulls row tick low
	logic row_tick;         // resolved row tick level
	logic ext_clk_val;      // supplied sampling clock value
	logic ext_clk_oe;       // supplier drives the pin
	logic ext_sample_clock; // resolved sampling pin

	// released data line reads high through the pull-up
	assign miso = miso_oe ? miso_val : 1'b1;
	assign int_line = ~int_oe;
	assign row_tick = ~row_tick_oe;
	assign ext_sample_clock = ext_clk_oe & ext_clk_val;

	modport dev (
		input  ss_n, sclk, mosi, ext_sample_clock,
		output miso_val, miso_oe, int_oe, row_tick_oe
	);
	modport host (
		output ss_n, sclk, mosi, ext_clk_val, ext_clk_oe,
		input  miso, int_line, row_tick
	);
endinterface
`default_nettype wire

// File: core/row_timer.sv
// Purpose: row slot timer for the row tick and marker positions
// Assumes: tick_in is one divided sampling period
// Notes: last slot of a row is the low time
`default_nettype none
module row_timer #(
	parameter int CW = 17
) (
	input  wire logic                     ref_clk_in,
	input  wire logic                     rst_n_in,
	input  wire logic                     run_in,
	input  wire logic                     restart_in,
	input  wire logic                     extra_in,
	input  wire logic                     tick_in,
	input  wire logic [CW-1:0]            slot_len_in,
	output logic                          slot_end_out,
	output logic [voice_pkg::SLOT_W-1:0]  slot_idx_out,
	output logic                          row_end_out,
	output logic                          low_out
);
	import voice_pkg::*;

	logic [CW-1:0]     cnt;   // cycles within the slot
	logic [SLOT_W-1:0] slot;  // position within the row
	logic              extra; // leading extra high slot
	logic              last;  // final cycle of a slot

	generate
		if (CW < 2) begin : g_bad
			$error("row_timer counter too narrow");
		end
	endgenerate

	assign last = run_in & tick_in & (cnt == slot_len_in - 1'b1);

	// slot counter, cleared by a restart
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in || restart_in) begin
			cnt   <= '0;
			slot  <= '0;
			// extra high slot on record start
			extra <= rst_n_in & extra_in;
		end else if (!run_in) begin
			cnt   <= '0;
			slot  <= '0;
			extra <= 1'b0;
		end else if (last) begin
			cnt <= '0;
			if (extra) begin
				extra <= 1'b0;
			end else begin
				slot <= slot + 1'b1;
			end
		end else if (tick_in) begin
			cnt <= cnt + 1'b1;
		end
	end

	assign slot_end_out = last & ~extra;
	assign slot_idx_out = slot;
	// one row ends with the final slot
	assign row_end_out = slot_end_out & (slot == SLOT_W'(ROW_SLOTS - 1));
	// low only during the final slot
	assign low_out = run_in & ~extra & (slot == SLOT_W'(ROW_SLOTS - 1));
endmodule // row_timer
`default_nettype wire

// File: core/voice_dev_end.sv
// Purpose: recorder end of the serial link, flags and row tick
// Assumes: pins synchronous to the reference clock
// Notes: marker memory stands in for the storage array
`default_nettype none
module voice_dev_end #(
	parameter int SLOT_CYCLES      = voice_pkg::ROW_LOW_CYCLES,
	parameter int SKIP_SLOT_CYCLES = voice_pkg::SKIP_LOW_CYCLES,
	parameter int INT_DIV          = voice_pkg::INT_DIV_CYCLES,
	parameter int ROWS             = voice_pkg::ROWS
) (
	input  wire logic        ref_clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        ext_clock_sel_in,
	spi_link_if.dev          link,
	output voice_pkg::op_e   op_out,
	output logic [15:0]      row_out,
	output logic             powered_out,
	output logic             array_end_flag_out,
	output logic             message_end_flag_out
);
	import voice_pkg::*;

	localparam int CW = $clog2(SLOT_CYCLES + 1);
	localparam int RW = $clog2(ROWS);
	localparam int DW = $clog2(INT_DIV + 1);

	// refuse settings the counters cannot serve
	generate
		if (ROWS < 2 || ROWS > 65536) begin : g_bad_rows
			$error("row count out of range");
		end
		if (SKIP_SLOT_CYCLES < 1 || SKIP_SLOT_CYCLES > SLOT_CYCLES)
		begin : g_bad_skip
			$error("skip slot longer than normal slot");
		end
		if (INT_DIV < 2) begin : g_bad_div
			$error("internal divider too small");
		end
	endgenerate

	// pin history for edge detection
	logic ss_q;
	logic sclk_q;
	logic ext_q;
	logic ext_half;  // divide-by-two phase
	logic [DW-1:0] int_cnt;  // internal sampling divider
	logic ext_tick;
	logic int_tick;
	logic div_tick;  // one divided sampling period

	// serial shift state
	logic [FRAME_BITS-1:0] rx;
	logic [FRAME_BITS-1:0] tx;
	logic [4:0]            bit_cnt;

	// operation state
	op_e             op;
	logic            skip;       // message_skip_mode
	logic [RW-1:0]   row;
	logic            powered;
	logic            array_end_flag;
	logic            message_end_flag;
	logic            int_pend;
	logic [ROW_SLOTS-1:0] marks [ROWS];  // marker bits per row

	logic sel;
	logic ss_fall;
	logic ss_rise;
	logic sclk_rise;
	logic sclk_fall;
	logic cmd_take;
	logic cmd_start;
	logic rec_stop;
	logic [7:0] ctrl;
	logic [ADDR_BITS-1:0] addr;
	logic slot_end;
	logic row_end;
	logic row_low;
	logic [SLOT_W-1:0] slot_idx;
	logic play_msg_end;
	logic array_end;
	logic op_end;
	logic [CW-1:0] slot_len;

	// selected only while select is low
	assign sel = ~link.ss_n;
	assign ss_fall = ~link.ss_n & ss_q;
	assign ss_rise = link.ss_n & ~ss_q;
	// clock edges come only from the host
	assign sclk_rise = sel & link.sclk & ~sclk_q;
	assign sclk_fall = sel & ~link.sclk & sclk_q;

	// pin history registers
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			ss_q   <= 1'b1;
			sclk_q <= 1'b0;
			ext_q  <= 1'b0;
		end else begin
			ss_q   <= link.ss_n;
			sclk_q <= link.sclk;
			ext_q  <= link.ext_sample_clock;
		end
	end

	// halve the supplied clock on entry
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			ext_half <= 1'b0;
		end else if (link.ext_sample_clock && !ext_q) begin
			ext_half <= ~ext_half;
		end
	end
	// only rising edges count, so duty cycle is irrelevant
	assign ext_tick = link.ext_sample_clock & ~ext_q & ext_half;

	// internal sampling source when no clock is supplied
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in || int_tick) begin
			int_cnt <= '0;
		end else begin
			int_cnt <= int_cnt + 1'b1;
		end
	end
	assign int_tick = (int_cnt == DW'(INT_DIV - 1));
	assign div_tick = ext_clock_sel_in ? ext_tick : int_tick;

	// serial shift in and out
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			rx      <= '0;
			tx      <= '1;
			bit_cnt <= '0;
		end else if (ss_fall) begin
			bit_cnt <= '0;
			// status word ready before the first edge
			tx <= '0;
			tx[STAT_ARRAY_POS] <= array_end_flag;
			tx[STAT_MSG_POS]   <= message_end_flag;
			tx[STAT_ROW_POS +: ADDR_BITS] <= ADDR_BITS'(row);
		end else begin
			if (sclk_rise && bit_cnt < 5'(FRAME_BITS)) begin
				rx[bit_cnt] <= link.mosi;
				bit_cnt     <= bit_cnt + 1'b1;
			end
			// change output on the falling edge
			if (sclk_fall && bit_cnt != 5'h00) begin
				tx <= {1'b1, tx[FRAME_BITS-1:1]};
			end
		end
	end

	// flags leave first during the control byte
	assign link.miso_val = tx[0];
	assign link.miso_oe = sel;

	// command decode at the end of a transaction
	assign ctrl = rx[CTRL_BITS-1:0];
	assign addr = rx[CTRL_BITS +: ADDR_BITS];
	// short frames carry no command
	assign cmd_take = ss_rise & (bit_cnt >= 5'(CTRL_BITS));
	// a read flags byte only stops, it starts nothing
	assign cmd_start = cmd_take & ctrl[CMD_RUN_BIT] & ctrl[CMD_PU_BIT]
		& ~read_flags_cmd(ctrl);
	assign rec_stop = cmd_take & (op == OP_REC);

	// skip mode uses the short slot
	assign slot_len = skip ? CW'(SKIP_SLOT_CYCLES) : CW'(SLOT_CYCLES);

	// row timing counted in divided cycles
	row_timer #(
		.CW (CW)
	) u_row_timer (
		.ref_clk_in   (ref_clk_in),
		.rst_n_in     (rst_n_in),
		.run_in       (op != OP_IDLE),
		.restart_in   (cmd_start),
		.extra_in     (~ctrl[CMD_PLAY_BIT]),
		.tick_in      (div_tick),
		.slot_len_in  (slot_len),
		.slot_end_out (slot_end),
		.slot_idx_out (slot_idx),
		.row_end_out  (row_end),
		.low_out      (row_low)
	);

	// open drain row tick pulled low in the low slot
	assign link.row_tick_oe = row_low;

	// message end only while playing a marker
	assign play_msg_end = (op == OP_PLAY) & slot_end
		& marks[row][slot_idx];
	// end of the last row reached while recording or playing
	assign array_end = (op != OP_IDLE) & row_end
		& (row == RW'(ROWS - 1));
	// any ending by marker or array end
	assign op_end = play_msg_end | array_end;

	// operation, row pointer and power state
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			op      <= OP_IDLE;
			skip    <= 1'b0;
			row     <= '0;
			powered <= 1'b0;
		end else if (cmd_take) begin
			powered <= ctrl[CMD_PU_BIT];
			if (cmd_start) begin
				op   <= ctrl[CMD_PLAY_BIT] ? OP_PLAY : OP_REC;
				skip <= ctrl[CMD_PLAY_BIT] & ctrl[CMD_SKIP_BIT];
				// out of range addresses keep the old row
				if (!ctrl[CMD_IAB_BIT]
					&& bit_cnt == 5'(FRAME_BITS)
					&& addr < ADDR_BITS'(ROWS)) begin
					row <= RW'(addr);
				end
			end else begin
				op <= OP_IDLE;
			end
		end else if (op_end) begin
			op <= OP_IDLE;
		end else if (row_end) begin
			row <= row + 1'b1;
		end
	end

	// status flags, a new operation clears them
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			array_end_flag   <= 1'b0;
			message_end_flag <= 1'b0;
		end else begin
			if (cmd_start) begin
				array_end_flag   <= 1'b0;
				message_end_flag <= 1'b0;
			end
			if (array_end) begin
				array_end_flag <= 1'b1;
			end
			if (play_msg_end) begin
				message_end_flag <= 1'b1;
			end
		end
	end

	// pending interrupt
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			int_pend <= 1'b0;
		end else if (op_end) begin
			int_pend <= 1'b1;
		end else if (ss_fall) begin
			int_pend <= 1'b0;
		end
	end
	// open drain, only ever pulls low
	assign link.int_oe = int_pend;

	// marker memory, recording rewrites the positions it passes
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < ROWS; i++) begin
				marks[i] <= '0;
			end
		end else if (rec_stop) begin
			marks[row][slot_idx] <= 1'b1;
		end else if (op == OP_REC && slot_end) begin
			marks[row][slot_idx] <= 1'b0;
		end
	end

	assign op_out               = op;
	assign row_out              = 16'(row);
	assign powered_out          = powered;
	assign array_end_flag_out   = array_end_flag;
	assign message_end_flag_out = message_end_flag;
endmodule // voice_dev_end
`default_nettype wire

// File: core/voice_host_end.sv
// Purpose: host end, serial master and sampling clock source
// Assumes: one command frame at a time
// Notes: clock idles low, bits go least significant first
`default_nettype none
module voice_host_end #(
	parameter int SCLK_HALF = voice_pkg::SCLK_HALF_CYCLES,
	parameter int SS_GAP    = voice_pkg::SS_GAP_CYCLES,
	parameter int EXT_HALF  = voice_pkg::EXT_HALF_CYCLES
) (
	input  wire logic        ref_clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        ext_clock_enable_in,
	input  wire logic        cmd_valid_in,
	input  wire logic        cmd_long_in,
	input  wire logic [7:0]  cmd_ctrl_in,
	input  wire logic [15:0] cmd_addr_in,
	output logic             cmd_ready_out,
	output logic             resp_valid_out,
	output logic [23:0]      resp_data_out,
	output logic             irq_out,
	spi_link_if.host         link
);
	import voice_pkg::*;

	localparam int TW = $clog2(SCLK_HALF + SS_GAP + 1);
	localparam int EW = $clog2(EXT_HALF + 1);

	generate
		if (SCLK_HALF < 2 || SS_GAP < 1 || EXT_HALF < 1) begin : g_bad
			$error("host timing parameters too small");
		end
	endgenerate

	host_state_e           st;
	logic [TW-1:0]         tim;     // cycles in the current phase
	logic [4:0]            nbits;   // frame length
	logic [4:0]            bit_i;   // bits clocked so far
	logic [FRAME_BITS-1:0] txd;     // outgoing bits, bit 0 on the pin
	logic [FRAME_BITS-1:0] rxd;     // incoming bits
	logic                  ss_n;
	logic                  sclk;
	logic                  half_done;
	logic                  gap_done;
	logic [EW-1:0]         ext_cnt;
	logic                  ext_clk;
	logic                  irq;

	assign half_done = (tim == TW'(SCLK_HALF - 1));
	assign gap_done  = (tim == TW'(SS_GAP - 1));

	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			st    <= HS_IDLE;
			tim   <= '0;
			nbits <= '0;
			bit_i <= '0;
			txd   <= '0;
			rxd   <= '0;
			ss_n  <= 1'b1;
			sclk  <= 1'b0;
			resp_valid_out <= 1'b0;
			resp_data_out  <= '0;
		end else begin
			resp_valid_out <= 1'b0;
			tim <= tim + 1'b1;
			case (st)
				HS_IDLE: begin
					tim <= '0;
					if (cmd_valid_in) begin
						ss_n  <= 1'b0;
						txd   <= {cmd_addr_in, cmd_ctrl_in};
						nbits <= cmd_long_in ? 5'(FRAME_BITS)
							: 5'(CTRL_BITS);
						bit_i <= '0;
						rxd   <= '0;
						st    <= HS_LOW;
					end
				end
				HS_LOW: begin
					if (half_done) begin
						tim <= '0;
						if (bit_i == nbits) begin
							ss_n <= 1'b1;
							resp_valid_out <= 1'b1;
							resp_data_out  <= rxd;
							st <= HS_GAP;
						end else begin
							// data stood for half a period
							sclk <= 1'b1;
							rxd[bit_i] <= link.miso;
							st <= HS_HIGH;
						end
					end
				end
				HS_HIGH: begin
					if (half_done) begin
						tim   <= '0;
						sclk  <= 1'b0;
						bit_i <= bit_i + 1'b1;
						txd   <= {1'b0, txd[FRAME_BITS-1:1]};
						st    <= HS_LOW;
					end
				end
				HS_GAP: begin
					if (gap_done) begin
						tim <= '0;
						st  <= HS_IDLE;
					end
				end
				default: begin
					st <= HS_IDLE;
				end
			endcase
		end
	end

	assign link.ss_n = ss_n;
	assign link.sclk = sclk;
	assign link.mosi = txd[0];
	assign cmd_ready_out = (st == HS_IDLE);

	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			ext_cnt <= '0;
			ext_clk <= 1'b0;
		end else if (ext_cnt == EW'(EXT_HALF - 1)) begin
			ext_cnt <= '0;
			ext_clk <= ~ext_clk;
		end else begin
			ext_cnt <= ext_cnt + 1'b1;
		end
	end
	// pin held at ground when unused
	assign link.ext_clk_oe  = 1'b1;
	assign link.ext_clk_val = ext_clock_enable_in & ext_clk;

	// interrupt seen by the host, high while the line is pulled low
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			irq <= 1'b0;
		end else begin
			irq <= ~link.int_line;
		end
	end
	assign irq_out = irq;
endmodule // voice_host_end
`default_nettype wire

// File: sim/voice_link_checker.sv
// Purpose: wire checks between the recorder and host ends
// Assumes: one clock, rows timed by the internal divider
// Notes: run lengths accept a normal or a skip row
`default_nettype none
module voice_link_checker #(
	parameter int LOWC  = 32, // ref cycles of a normal low slot
	parameter int SKIPL = 8   // ref cycles of a skip low slot
) (
	input  wire logic ref_clk_in,
	input  wire logic rst_n_in,
	input  wire logic ss_n,
	input  wire logic sclk,
	input  wire logic miso_val,
	input  wire logic miso_oe,
	input  wire logic int_oe,
	input  wire logic row_tick_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [19:0] low_cnt; // cycles the row tick has been low
	logic [19:0] hi_cnt;  // cycles since the row tick went high
	logic        hi_ok;   // high run began at a row end, not a start
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_n_in);
	// low run counter, cleared whenever the tick is released
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in || !row_tick_oe)
			low_cnt <= 20'h0;
		else
			low_cnt <= low_cnt + 20'h1;
	end
	// high run counter; a select cancels it, rows restart there
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in || row_tick_oe)
			hi_cnt <= 20'h0;
		else
			hi_cnt <= hi_cnt + 20'h1;
		if (!rst_n_in || !ss_n)
			hi_ok <= 1'b0;
		else if (row_tick_oe)
			hi_ok <= 1'b1;
	end
	a_miso_released: assert property (
		ss_n && $past(ss_n) |-> !miso_oe)
		else $error("data out driven while deselected");
	a_miso_driven: assert property (
		!ss_n && !$past(ss_n) |-> miso_oe)
		else $error("data out idle while selected");
	a_miso_fall_only: assert property (
		!ss_n && !$past(ss_n) && $changed(miso_val) |-> !sclk)
		else $error("data out moved while clock high");
	a_miso_hold_high: assert property (
		!ss_n && sclk && $past(sclk) |-> $stable(miso_val))
		else $error("data out unstable in high phase");
	a_int_holds: assert property (
		int_oe && ss_n |=> int_oe)
		else $error("interrupt dropped without a select");
	a_int_sel_clear: assert property (
		$fell(ss_n) |-> ##[1:3] !int_oe)
		else $error("interrupt kept after select fall");
	a_int_release_sel: assert property (
		$fell(int_oe) |-> !ss_n)
		else $error("interrupt released while deselected");
	a_row_low_len: assert property (
		$fell(row_tick_oe) |-> low_cnt == LOWC || low_cnt == SKIPL)
		else $error("row low time wrong");
	a_row_high_len: assert property (
		$rose(row_tick_oe) && hi_ok
		|-> hi_cnt == 7 * LOWC || hi_cnt == 7 * SKIPL)
		else $error("row high time wrong");
	c_int_raised: cover property ($rose(int_oe));
	c_skip_row: cover property ($fell(row_tick_oe) && low_cnt == SKIPL);
	c_full_row: cover property ($rose(row_tick_oe) && hi_ok);
endmodule // voice_link_checker
`default_nettype wire

// File: sim/voice_recorder_serial_status_tb_top.sv
// Purpose: both link ends driven through the host command port
// Assumes: short rows, four rows, internal sampling divider
// Notes: markers are laid by stopping a recording mid row
`default_nettype none
module voice_recorder_serial_status_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import voice_pkg::*;
	localparam int SLOT  = 8;           // divided ticks per slot
	localparam int DIV   = 4;           // ref cycles per tick
	localparam int SLOTC = SLOT * DIV;  // ref cycles per slot
	logic            ref_clk_in;
	logic            rst_n_in;
	logic            ext_sel;          // row timing source, internal
	logic            ext_en;           // sampling pin held low until the last check
	logic            cmd_valid_in;
	logic            cmd_long_in;
	logic [7:0]      cmd_ctrl_in;
	logic [15:0]     cmd_addr_in;
	logic            cmd_ready_out;
	logic            resp_valid_out;
	logic [23:0]     resp_data_out;
	logic            irq_out;
	op_e             op_out;
	logic [23:0]     resp;             // last reply seen
	int              ext_n;            // cycles spent on a pin level
	int              errors;
	int              checked;
	spi_link_if link();
	voice_dev_end #(.SLOT_CYCLES(SLOT), .SKIP_SLOT_CYCLES(2),
		.INT_DIV(DIV), .ROWS(4)) i_voice_dev_end (
		.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
		.ext_clock_sel_in(ext_sel), .link(link.dev),
		.op_out(op_out), .row_out(), .powered_out(),
		.array_end_flag_out(), .message_end_flag_out());
	voice_host_end i_voice_host_end (
		.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
		.ext_clock_enable_in(ext_en), .cmd_valid_in(cmd_valid_in),
		.cmd_long_in(cmd_long_in), .cmd_ctrl_in(cmd_ctrl_in),
		.cmd_addr_in(cmd_addr_in), .cmd_ready_out(cmd_ready_out),
		.resp_valid_out(resp_valid_out), .resp_data_out(resp_data_out),
		.irq_out(irq_out), .link(link.host));
	voice_link_checker #(.LOWC(SLOTC), .SKIPL(2 * DIV))
		i_voice_link_checker (
		.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
		.ss_n(link.ss_n), .sclk(link.sclk), .miso_val(link.miso_val),
		.miso_oe(link.miso_oe), .int_oe(link.int_oe),
		.row_tick_oe(link.row_tick_oe));
	// 40 MHz reference
	initial begin
		ref_clk_in = 1'b0;
		forever #12.5 ref_clk_in = ~ref_clk_in;
	end
	task automatic complete_run();
		$display("errors=%0d checked=%0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic give_up();
		errors++;
		complete_run();
	endtask
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one frame: wait idle, pulse valid one edge, wait for the reply
	task automatic send(input logic [7:0] c, input logic [15:0] a,
		input logic lng);
		int n;
		for (n = 0; cmd_ready_out !== 1'b1; n++) begin
			if (n > 200)
				give_up();
			@(negedge ref_clk_in);
		end
		@(posedge ref_clk_in);
		cmd_ctrl_in <= c;
		cmd_addr_in <= a;
		cmd_long_in <= lng;
		cmd_valid_in <= 1'b1;
		@(posedge ref_clk_in);
		cmd_valid_in <= 1'b0;
		for (n = 0; resp_valid_out !== 1'b1; n++) begin
			if (n > 1000)
				give_up();
			@(negedge ref_clk_in);
		end
		resp = resp_data_out;
	endtask
	// 8-bit frame; only the two flag bits may be set
	task automatic flags(input logic [7:0] c, input logic [1:0] exp);
		send(c, 16'h0000, 1'b0);
		chk(24'(resp[7:0]), 24'(exp));
	endtask
	task automatic wait_irq();
		int n;
		for (n = 0; irq_out !== 1'b1; n++) begin
			if (n > 5000)
				give_up();
			@(negedge ref_clk_in);
		end
	endtask
	// waits for a level on the sampling pin, returns cycles spent
	task automatic ext_wait(input logic v, output int n);
		for (n = 0; link.ext_sample_clock !== v; n++) begin
			if (n > 200)
				give_up();
			@(negedge ref_clk_in);
		end
	endtask
	// divider phase is free, so the first low gets a small window
	task automatic first_low(input int exp);
		int n;
		for (n = 0; link.row_tick !== 1'b0; n++) begin
			if (n > 2000)
				give_up();
			@(negedge ref_clk_in);
		end
		chk(24'(n >= exp - 4 && n <= exp + 8), 24'h1);
	endtask
	initial begin
		errors = 0;
		checked = 0;
		rst_n_in = 1'b0;
		ext_sel = 1'b0;
		ext_en = 1'b0;
		cmd_valid_in = 1'b0;
		cmd_long_in = 1'b0;
		cmd_ctrl_in = 8'h00;
		cmd_addr_in = 16'h0000;
		repeat (2) @(posedge ref_clk_in);
		rst_n_in <= 1'b1;
		flags(8'h30, 2'b00);
		// record from row 0 into the array end
		send(8'hA0, 16'h0000, 1'b1);
		first_low(8 * SLOTC);
		wait_irq();
		repeat (20) @(negedge ref_clk_in);
		chk(24'(irq_out), 24'h1);
		chk(24'(op_out), 24'(OP_IDLE));
		flags(8'h30, 2'b01);
		chk(24'(irq_out), 24'h0);
		// record from row 1, stopped mid row 2 to leave a marker
		send(8'hA0, 16'h0001, 1'b1);
		first_low(8 * SLOTC);
		send(8'h20, 16'h0000, 1'b0);
		send(8'hE0, 16'h0001, 1'b1);
		first_low(7 * SLOTC);
		wait_irq();
		flags(8'h30, 2'b10);
		// skip mode from row 0 halts on the same marker
		send(8'hE8, 16'h0000, 1'b1);
		first_low(7 * 2 * DIV);
		wait_irq();
		flags(8'h77, 2'b10);
		// playback into the last row
		send(8'hE0, 16'h0003, 1'b1);
		wait_irq();
		flags(8'h37, 2'b01);
		// full frame read returns flags and the row left at the end
		send(8'h30, 16'h0000, 1'b1);
		chk(resp, 24'h000301);
		chk(24'(link.ext_sample_clock), 24'h0);
		// supplied sampling clock: low half of one period
		@(posedge ref_clk_in);
		ext_en <= 1'b1;
		ext_wait(1'b1, ext_n);
		ext_wait(1'b0, ext_n);
		ext_wait(1'b1, ext_n);
		chk(24'(ext_n), 24'(EXT_HALF_CYCLES));
		complete_run();
	end
endmodule // voice_recorder_serial_status_tb_top
`default_nettype wire
